// [rpe_engine.sv]
// Behaviour
// - Request is new when command toggle changes and equals the length toggle.
// - Status and data are written first, both echo bytes one cycle later.
// - Toggle changes seen while a request is busy are absorbed and ignored.
// - Commands 01 read, 02 write, 08 enable, 09 disable, 0A clear hot-swap.
// - Read needs pre-operational or operational node, write operational, else 85.
// - Status top bit always shows whether the service is enabled.
// - Success reports 80, a successful disable reports 00.
// - Any command but enable while disabled is not run, status 01.
// - Error codes 82 to 89 for command, length, node, state, index, size, bus, self-write.
// - Aborted transfer reports 90 with the abort code as data.
// - Any other failure reports general status FF, or 7F while the service is disabled.
// - Response words readable as object 4100, sub-indices 1 to 4.
// - Words hold status plus echo, data LSB first, trailing echo.
// - Request is five 16-bit words, toggles at both ends.
// - Index, length and command range checks per command.
// - Nodes 1 to 32 and 127 only.
`timescale 1ns/10ps
module rpe_engine
  import rpe_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [15:0] req_sub_len_in,
  input wire logic [15:0] req_index_in,
  input wire logic [15:0] req_data_low_in,
  input wire logic [15:0] req_data_high_in,
  input wire logic [15:0] req_cmd_node_in,
  input wire logic service_configured_in,
  input wire logic [31:0] node_preop_in,
  input wire logic [31:0] node_oper_in,
  output logic xfer_req_out,
  output logic [1:0] xfer_kind_out,
  output logic [7:0] xfer_node_out,
  output logic [15:0] xfer_index_out,
  output logic [7:0] xfer_sub_out,
  output logic [6:0] xfer_len_out,
  output logic [31:0] xfer_wdata_out,
  input wire logic xfer_done_in,
  input wire logic [2:0] xfer_result_in,
  input wire logic [31:0] xfer_rdata_in,
  output logic service_enabled_out,
  output logic [15:0] resp_status_echo_out,
  output logic [15:0] resp_data_low_out,
  output logic [15:0] resp_data_high_out,
  output logic [15:0] resp_trailing_echo_out,
  input wire logic obj_rd_in,
  input wire logic [15:0] obj_index_in,
  input wire logic [7:0] obj_sub_in,
  output logic obj_ack_out,
  output logic obj_err_out,
  output logic [15:0] obj_data_out
);
  rpe_state_t state_q, state_d;
  logic last_tog_q, last_tog_d;
  logic en_q, en_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] node_q, node_d;
  logic [15:0] idx_q, idx_d;
  logic [7:0] sub_q, sub_d;
  logic [6:0] len_q, len_d;
  logic [31:0] wdata_q, wdata_d;
  logic [7:0] status_q, status_d;
  logic [31:0] rdata_q, rdata_d;
  logic xreq_q, xreq_d;
  rpe_xkind_t xkind_q, xkind_d;
  logic tog_cmd, tog_len, tog_match, new_req;
  logic node_isl, len_ok, node_pre, node_op;
  logic [4:0] node_sel;
  logic [7:0] code;

  rpe_resp_if rif ();

  rpe_resp_bank u_bank (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .rb(rif.bank)
  );

  ////////////////////////////////////////////////////////////////////////
  // toggle detection
  assign tog_cmd = req_cmd_node_in[TOG_CMD_BIT];
  assign tog_len = req_sub_len_in[TOG_LEN_BIT];
  assign tog_match = (tog_cmd == tog_len);
  assign new_req = tog_match && (tog_cmd != last_tog_q);

  // Latched request decode
  assign node_isl = (node_q >= NODE_FIRST) && (node_q <= NODE_LAST);
  assign node_sel = 5'(node_q - NODE_FIRST);
  assign node_pre = node_preop_in[node_sel];
  assign node_op = node_oper_in[node_sel];
  assign len_ok = (len_q >= LEN_MIN) && (len_q <= LEN_MAX);

  ////////////////////////////////////////////////////////////////////////
  // Engine next state
  always_comb
  begin
    state_d = state_q;
    last_tog_d = last_tog_q;
    en_d = en_q;
    cmd_d = cmd_q;
    node_d = node_q;
    idx_d = idx_q;
    sub_d = sub_q;
    len_d = len_q;
    wdata_d = wdata_q;
    status_d = status_q;
    rdata_d = rdata_q;
    xreq_d = xreq_q;
    xkind_d = xkind_q;
    code = STS_GENERAL;
    case (state_q)
      ST_IDLE:
      begin
        // take request on matching new toggle
        if (new_req)
        begin
          last_tog_d = tog_cmd;
          cmd_d = req_cmd_node_in[15:8];
          node_d = req_cmd_node_in[7:0];
          idx_d = req_index_in;
          sub_d = req_sub_len_in[15:8];
          len_d = req_sub_len_in[6:0];
          wdata_d = {req_data_high_in, req_data_low_in};
          state_d = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        state_d = ST_POST;
        rdata_d = DATA_RST;
        if (!en_q && cmd_q[6:0] != CMD_ENABLE)
          code = STS_NOT_ENABLED;
        else
        begin
          case (cmd_q[6:0])
            CMD_ENABLE, CMD_DISABLE:
            begin
              if (node_q != NODE_SELF)
                code = STS_BAD_NODE;
              else if (cmd_q[6:0] == CMD_ENABLE && !service_configured_in)
                code = STS_GENERAL;
              else
              begin
                en_d = (cmd_q[6:0] == CMD_ENABLE);
                code = STS_OK;
              end
            end
            CMD_READ:
            begin
              if (!node_isl && node_q != NODE_SELF)
                code = STS_BAD_NODE;
              else if (!len_ok)
                code = STS_BAD_LEN;
              else if (idx_q < IDX_READ_MIN)
                code = STS_BAD_INDEX;
              else if (node_isl && !node_pre && !node_op)
                code = STS_BAD_STATE;
              else
              begin
                xreq_d = 1'b1;
                xkind_d = XK_READ;
                state_d = ST_XFER;
              end
            end
            CMD_WRITE:
            begin
              if (node_q == NODE_SELF)
                code = STS_WR_SELF;
              else if (!node_isl)
                code = STS_BAD_NODE;
              else if (!len_ok)
                code = STS_BAD_LEN;
              else if (idx_q < IDX_WRITE_MIN)
                code = STS_BAD_INDEX;
              else if (!node_op)
                code = STS_BAD_STATE;
              else
              begin
                xreq_d = 1'b1;
                xkind_d = XK_WRITE;
                state_d = ST_XFER;
              end
            end
            CMD_CLR_HOTSWAP:
            begin
              if (!node_isl)
                code = STS_BAD_NODE;
              else
              begin
                xreq_d = 1'b1;
                xkind_d = XK_CLR_HOTSWAP;
                state_d = ST_XFER;
              end
            end
            default: code = STS_BAD_CMD;
          endcase
        end
        // top bit carries the enable state
        status_d = {en_d, code[6:0]};
      end
      ST_XFER:
      begin
        if (xfer_done_in)
        begin
          xreq_d = 1'b0;
          state_d = ST_POST;
          case (rpe_xres_t'(xfer_result_in))
            XR_OK: code = STS_OK;
            XR_ABORT: code = STS_SDO_ABORT;
            XR_NO_BUS: code = STS_NO_BUS;
            XR_TOO_LONG: code = STS_TOO_LONG;
            XR_BAD_INDEX: code = STS_BAD_INDEX;
            default: code = STS_GENERAL;
          endcase
          rdata_d = (code == STS_OK || code == STS_SDO_ABORT) ? xfer_rdata_in : DATA_RST;
          status_d = {en_q, code[6:0]};
        end
      end
      ST_POST: state_d = ST_ECHO;
      ST_ECHO: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    // absorb toggles that flip while busy
    if (state_q != ST_IDLE && tog_match)
      last_tog_d = tog_cmd;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ST_IDLE;
      last_tog_q <= 1'b0;
      en_q <= 1'b0;
      cmd_q <= BYTE_RST;
      node_q <= BYTE_RST;
      idx_q <= RESP_WORD_RST;
      sub_q <= BYTE_RST;
      len_q <= 7'h00;
      wdata_q <= DATA_RST;
      status_q <= BYTE_RST;
      rdata_q <= DATA_RST;
      xreq_q <= 1'b0;
      xkind_q <= XK_READ;
    end
    else
    begin
      state_q <= state_d;
      last_tog_q <= last_tog_d;
      en_q <= en_d;
      cmd_q <= cmd_d;
      node_q <= node_d;
      idx_q <= idx_d;
      sub_q <= sub_d;
      len_q <= len_d;
      wdata_q <= wdata_d;
      status_q <= status_d;
      rdata_q <= rdata_d;
      xreq_q <= xreq_d;
      xkind_q <= xkind_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data first, echo one cycle later
  assign rif.data_we = (state_q == ST_POST);
  assign rif.status = status_q;
  assign rif.data = rdata_q;
  assign rif.echo_we = (state_q == ST_ECHO);
  assign rif.echo = cmd_q;
  // object view of the response words
  assign rif.rd_en = obj_rd_in;
  assign rif.rd_index = obj_index_in;
  assign rif.rd_sub = obj_sub_in;

  // Outputs, all from flops
  assign xfer_req_out = xreq_q;
  assign xfer_kind_out = xkind_q;
  assign xfer_node_out = node_q;
  assign xfer_index_out = idx_q;
  assign xfer_sub_out = sub_q;
  assign xfer_len_out = len_q;
  assign xfer_wdata_out = wdata_q;
  assign service_enabled_out = en_q;
  assign resp_status_echo_out = rif.words[0];
  assign resp_data_low_out = rif.words[1];
  assign resp_data_high_out = rif.words[2];
  assign resp_trailing_echo_out = rif.words[3];
  assign obj_ack_out = rif.rd_ack;
  assign obj_err_out = rif.rd_err;
  assign obj_data_out = rif.rd_data;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_new_req_taken: assert property ((state_q == ST_IDLE && new_req) |=>
    (state_q == ST_CHECK) && (cmd_q == $past(req_cmd_node_in[15:8])))
    else $error("new request not taken");
  a_busy_ignore: assert property ((state_q != ST_IDLE && state_q != ST_ECHO) |=>
    $stable(cmd_q) && $stable(idx_q))
    else $error("request changed while busy");
  a_status_first: assert property ((state_q == ST_POST) |=>
    (resp_status_echo_out[15:8] == $past(status_q)) && $stable(resp_trailing_echo_out))
    else $error("status not written before echo");
  a_echo_both: assert property ((state_q == ST_ECHO) |=>
    (resp_status_echo_out[7:0] == $past(cmd_q)) && (resp_trailing_echo_out[7:0] == $past(cmd_q)))
    else $error("echo bytes not set");
  a_status_msb: assert property ((state_q == ST_POST) |-> (status_q[7] == en_q))
    else $error("status top bit wrong");
  a_disabled_refuse: assert property ((state_q == ST_CHECK && !en_q &&
    cmd_q[6:0] != CMD_ENABLE) |=> (status_q == STS_NOT_ENABLED) && !xreq_q)
    else $error("disabled service ran a command");
  a_self_write: assert property ((state_q == ST_CHECK && en_q &&
    cmd_q[6:0] == CMD_WRITE && node_q == NODE_SELF) |=> status_q == STS_WR_SELF)
    else $error("write to self not refused");
  a_disable_ok: assert property ((state_q == ST_CHECK && en_q &&
    cmd_q[6:0] == CMD_DISABLE && node_q == NODE_SELF) |=> status_q == STS_DISABLED_OK ##2 !en_q)
    else $error("disable status wrong");
  a_abort_data: assert property ((state_q == ST_XFER && xfer_done_in &&
    xfer_result_in == XR_ABORT) |=> (status_q[6:0] == STS_SDO_ABORT[6:0])
    && (rdata_q == $past(xfer_rdata_in)))
    else $error("abort not reported");
  a_bad_len: assert property ((state_q == ST_CHECK && en_q && cmd_q[6:0] == CMD_READ
    && node_q == NODE_SELF && !len_ok) |=> (status_q == STS_BAD_LEN) && !xreq_q)
    else $error("bad length not refused");

  c_read_done: cover property ((state_q == ST_XFER && xfer_done_in && xfer_result_in == XR_OK)
    ##2 (state_q == ST_ECHO));
  c_enable: cover property ((state_q == ST_CHECK && cmd_q[6:0] == CMD_ENABLE) ##1 en_q);
  c_busy_toggle: cover property ((state_q == ST_XFER) && tog_match && tog_cmd != last_tog_q);
  c_obj_read: cover property (obj_ack_out && !obj_err_out);
endmodule : rpe_engine

// [rpe_pkg.sv]
package rpe_pkg;
  // Response block offsets and object view
  localparam logic [15:0] RESP_STATUS_ECHO_OFS = 16'hB0F7;
  localparam logic [15:0] RESP_DATA_LOW_OFS = 16'hB0F8;
  localparam logic [15:0] RESP_DATA_HIGH_OFS = 16'hB0F9;
  localparam logic [15:0] RESP_TRAILING_ECHO_OFS = 16'hB0FA;
  localparam logic [15:0] RESP_OBJ_INDEX = 16'h4100;
  localparam logic [7:0] RESP_OBJ_SUB_FIRST = 8'h01;
  localparam logic [7:0] RESP_OBJ_SUB_LAST = 8'h04;
  localparam logic [15:0] RESP_WORD_RST = 16'h0000;
  // Field positions in the request words
  localparam int TOG_LEN_BIT = 7;
  localparam int TOG_CMD_BIT = 15;
  // Command codes without the toggle bit
  localparam logic [6:0] CMD_READ = 7'h01;
  localparam logic [6:0] CMD_WRITE = 7'h02;
  localparam logic [6:0] CMD_ENABLE = 7'h08;
  localparam logic [6:0] CMD_DISABLE = 7'h09;
  localparam logic [6:0] CMD_CLR_HOTSWAP = 7'h0A;
  // Node and range limits
  localparam logic [7:0] NODE_FIRST = 8'h01;
  localparam logic [7:0] NODE_LAST = 8'h20;
  localparam logic [7:0] NODE_SELF = 8'h7F;
  localparam logic [15:0] IDX_WRITE_MIN = 16'h2000;
  localparam logic [15:0] IDX_READ_MIN = 16'h1000;
  localparam logic [6:0] LEN_MIN = 7'h01;
  localparam logic [6:0] LEN_MAX = 7'h04;
  // Status codes
  localparam logic [7:0] STS_OK = 8'h80;
  localparam logic [7:0] STS_DISABLED_OK = 8'h00;
  localparam logic [7:0] STS_NOT_ENABLED = 8'h01;
  localparam logic [7:0] STS_BAD_CMD = 8'h82;
  localparam logic [7:0] STS_BAD_LEN = 8'h83;
  localparam logic [7:0] STS_BAD_NODE = 8'h84;
  localparam logic [7:0] STS_BAD_STATE = 8'h85;
  localparam logic [7:0] STS_BAD_INDEX = 8'h86;
  localparam logic [7:0] STS_TOO_LONG = 8'h87;
  localparam logic [7:0] STS_NO_BUS = 8'h88;
  localparam logic [7:0] STS_WR_SELF = 8'h89;
  localparam logic [7:0] STS_SDO_ABORT = 8'h90;
  localparam logic [7:0] STS_GENERAL = 8'hFF;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // Engine states, Gray from idle through xfer to echo, not on check to post or on the return to idle
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHECK = 3'h1,
    ST_XFER = 3'h3,
    ST_POST = 3'h2,
    ST_ECHO = 3'h6
  } rpe_state_t;

  // Transfer kinds and results on the island side
  typedef enum logic [1:0] {
    XK_READ = 2'h0,
    XK_WRITE = 2'h1,
    XK_CLR_HOTSWAP = 2'h2
  } rpe_xkind_t;

  typedef enum logic [2:0] {
    XR_OK = 3'h0,
    XR_ABORT = 3'h1,
    XR_NO_BUS = 3'h2,
    XR_TOO_LONG = 3'h3,
    XR_BAD_INDEX = 3'h4,
    XR_OTHER = 3'h5
  } rpe_xres_t;
endpackage : rpe_pkg

// [rpe_resp_if.sv]
`timescale 1ns/10ps
interface rpe_resp_if;
  logic data_we;
  logic [7:0] status;
  logic [31:0] data;
  logic echo_we;
  logic [7:0] echo;
  logic rd_en;
  logic [15:0] rd_index;
  logic [7:0] rd_sub;
  logic [15:0] rd_data;
  logic rd_ack;
  logic rd_err;
  logic [3:0][15:0] words;
  modport eng (output data_we, status, data, echo_we, echo, rd_en, rd_index, rd_sub,
               input rd_data, rd_ack, rd_err, words);
  modport bank (input data_we, status, data, echo_we, echo, rd_en, rd_index, rd_sub,
                output rd_data, rd_ack, rd_err, words);
endinterface : rpe_resp_if

// [rpe_resp_bank.sv]
`timescale 1ns/10ps
module rpe_resp_bank
  import rpe_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  rpe_resp_if.bank rb
);
  logic [3:0][15:0] words_q, words_d;
  logic [15:0] rd_data_q, rd_data_d;
  logic rd_ack_q, rd_ack_d;
  logic rd_err_q, rd_err_d;
  logic sub_ok;

  ////////////////////////////////////////////////////////////////////////
  // Word updates and object read answer
  always_comb
  begin
    words_d = words_q;
    if (rb.data_we)
    begin
      words_d[0][15:8] = rb.status;
      words_d[1] = rb.data[15:0];
      words_d[2] = rb.data[31:16];
    end
    if (rb.echo_we)
    begin
      words_d[0][7:0] = rb.echo;
      words_d[3][7:0] = rb.echo;
    end
    sub_ok = (rb.rd_index == RESP_OBJ_INDEX) && (rb.rd_sub >= RESP_OBJ_SUB_FIRST)
             && (rb.rd_sub <= RESP_OBJ_SUB_LAST);
    rd_ack_d = rb.rd_en;
    rd_err_d = rb.rd_en && !sub_ok;
    rd_data_d = rd_data_q;
    if (rb.rd_en)
      rd_data_d = sub_ok ? words_q[rb.rd_sub[1:0] - 2'h1] : RESP_WORD_RST;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      words_q <= {4{RESP_WORD_RST}};
      rd_data_q <= RESP_WORD_RST;
      rd_ack_q <= 1'b0;
      rd_err_q <= 1'b0;
    end
    else
    begin
      words_q <= words_d;
      rd_data_q <= rd_data_d;
      rd_ack_q <= rd_ack_d;
      rd_err_q <= rd_err_d;
    end
  end

  assign rb.words = words_q;
  assign rb.rd_data = rd_data_q;
  assign rb.rd_ack = rd_ack_q;
  assign rb.rd_err = rd_err_q;
endmodule : rpe_resp_bank

// [rpe_master_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Request-side partner: fills the request block, then flips both toggles
module rpe_master_model (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [6:0] cmd_in,
  input wire logic [7:0] node_in,
  input wire logic [6:0] len_in,
  input wire logic [15:0] index_in,
  input wire logic [31:0] wdata_in,
  input wire logic [15:0] echo_first_in,
  input wire logic [15:0] echo_last_in,
  output logic [15:0] w0_out,
  output logic [15:0] w1_out,
  output logic [15:0] w2_out,
  output logic [15:0] w3_out,
  output logic [15:0] w4_out,
  output logic done_out
);
  logic tog_q;
  logic flip_q;
  // body words first, both toggles one cycle later
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      {w0_out, w1_out, w2_out, w3_out, w4_out} <= '0;
      tog_q <= 1'b0;
      flip_q <= 1'b0;
    end
    else if (start_in)
    begin
      w0_out <= {8'h03, tog_q, len_in};
      w1_out <= index_in;
      w2_out <= wdata_in[15:0];
      w3_out <= wdata_in[31:16];
      w4_out <= {tog_q, cmd_in, node_in};
      flip_q <= 1'b1;
    end
    else if (flip_q)
    begin
      w0_out[7] <= ~tog_q;
      w4_out[15] <= ~tog_q;
      tog_q <= ~tog_q;
      flip_q <= 1'b0;
    end
  end
  // response taken only when both echoes match
  assign done_out = !flip_q && !start_in && (echo_first_in[7:0] === w4_out[15:8])
                    && (echo_last_in[7:0] === w4_out[15:8]);
endmodule : rpe_master_model

// [tb_runtime_param_request_engine.sv]
`timescale 1ns/10ps
module tb_runtime_param_request_engine;
  import rpe_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic start = 1'b0;
  logic [69:0] m_req = '0;
  logic m_done;
  logic [15:0] req_sub_len_in, req_index_in, req_data_low_in, req_data_high_in, req_cmd_node_in;
  logic service_configured_in = 1'b0;
  logic [31:0] node_preop_in = 32'h0000_0006;
  logic [31:0] node_oper_in = 32'h0000_0030;
  logic xfer_req_out, service_enabled_out, obj_ack_out, obj_err_out;
  logic [1:0] xfer_kind_out;
  logic [7:0] xfer_node_out, xfer_sub_out;
  logic [15:0] xfer_index_out, obj_data_out;
  logic [6:0] xfer_len_out;
  logic [31:0] xfer_wdata_out;
  logic xfer_done_in = 1'b0;
  logic [2:0] xfer_result_in = 3'h7;
  logic [31:0] xfer_rdata_in = 32'hFFFF_FFFF;
  logic [15:0] resp_status_echo_out, resp_data_low_out;
  logic [15:0] resp_data_high_out, resp_trailing_echo_out;
  logic obj_rd_in = 1'b0;
  logic [15:0] obj_index_in = 16'h0000;
  logic [7:0] obj_sub_in = 8'h00;
  int isl_cnt = 0;
  int isl_wait = 0;
  logic isl_hold = 1'b0;
  logic [2:0] isl_res = 3'h0;
  logic [31:0] isl_data = 32'h0000_0000;
  logic [72:0] cap = '0;
  logic [31:0] cap_n = 32'h0000_0000;
  int fail_count = 0;
  int samples_checked = 0;
  localparam logic [47:0] ERR_TAB [14] = '{48'h03_7F_01_2000_82, 48'h00_7F_01_2000_82,
    48'h0B_7F_01_2000_82, 48'h01_7F_00_2000_83, 48'h01_05_05_2000_83, 48'h01_00_01_2000_84,
    48'h01_21_01_2000_84, 48'h01_05_01_0FFF_86, 48'h02_05_01_1FFF_86, 48'h02_7F_01_2000_89,
    48'h02_02_01_2000_85, 48'h01_04_01_1000_85, 48'h0A_7F_01_2000_84, 48'h09_01_01_2000_84};
  localparam logic [7:0] RD_STS [6] = '{8'h80, 8'h90, 8'h88, 8'h87, 8'h86, 8'hFF};

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, design and request partner
  always #50 clk_sys_in = ~clk_sys_in;

  rpe_engine uut (.clk_sys_in, .rst_n_in, .req_sub_len_in, .req_index_in, .req_data_low_in,
    .req_data_high_in, .req_cmd_node_in, .service_configured_in, .node_preop_in,
    .node_oper_in, .xfer_req_out, .xfer_kind_out, .xfer_node_out, .xfer_index_out,
    .xfer_sub_out, .xfer_len_out, .xfer_wdata_out, .xfer_done_in, .xfer_result_in,
    .xfer_rdata_in, .service_enabled_out, .resp_status_echo_out, .resp_data_low_out,
    .resp_data_high_out, .resp_trailing_echo_out, .obj_rd_in, .obj_index_in, .obj_sub_in,
    .obj_ack_out, .obj_err_out, .obj_data_out);

  rpe_master_model master (.clk_sys_in, .rst_n_in, .start_in(start),
    .cmd_in(m_req[69:63]), .node_in(m_req[62:55]), .len_in(m_req[54:48]),
    .index_in(m_req[47:32]), .wdata_in(m_req[31:0]),
    .echo_first_in(resp_status_echo_out), .echo_last_in(resp_trailing_echo_out),
    .w0_out(req_sub_len_in), .w1_out(req_index_in), .w2_out(req_data_low_in),
    .w3_out(req_data_high_in), .w4_out(req_cmd_node_in), .done_out(m_done));

  // Island side: records each transfer, answers after isl_wait cycles unless held
  always @(negedge clk_sys_in)
  begin
    if (xfer_req_out !== 1'b1)
    begin
      isl_cnt <= 0;
      xfer_done_in <= 1'b0;
      xfer_result_in <= ~isl_res;
      xfer_rdata_in <= ~isl_data;
    end
    else
    begin
      if (isl_cnt == 0)
      begin
        cap_n <= cap_n + 32'h1;
        cap <= {xfer_kind_out, xfer_node_out, xfer_index_out, xfer_sub_out, xfer_len_out,
                xfer_wdata_out};
      end
      isl_cnt <= isl_cnt + 1;
      xfer_done_in <= (isl_cnt >= isl_wait) && !isl_hold && !xfer_done_in;
      xfer_result_in <= isl_res;
      xfer_rdata_in <= isl_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared checking and request tasks
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic run(input logic [6:0] c, input logic [7:0] n, input logic [6:0] l,
                     input logic [15:0] ix, input logic [31:0] wd);
    int k;
    logic [7:0] ps;
    m_req = {c, n, l, ix, wd};
    start = 1'b1;
    @(negedge clk_sys_in);
    start = 1'b0;
    ps = resp_status_echo_out[15:8];
    for (k = 0; k < 100 && m_done !== 1'b1; k++)
    begin
      ps = resp_status_echo_out[15:8];
      @(negedge clk_sys_in);
    end
    if (m_done !== 1'b1)
    begin
      fail_count++;
      print_verdict;
    end
    chk("status_before_echo", ps, resp_status_echo_out[15:8]);
    chk("trailing_echo", resp_trailing_echo_out, {8'h00, req_cmd_node_in[15:8]});
  endtask : run

  task automatic rsp(input logic [7:0] s, input logic [31:0] d);
    chk("status", resp_status_echo_out, {s, req_cmd_node_in[15:8]});
    chk("data", {resp_data_high_out, resp_data_low_out}, d);
  endtask : rsp

  task automatic obj(input logic [15:0] ix, input logic [7:0] sb, input logic e,
                     input logic [15:0] d);
    obj_rd_in = 1'b1;
    obj_index_in = ix;
    obj_sub_in = sb;
    @(negedge clk_sys_in);
    obj_rd_in = 1'b0;
    chk("obj_read", {obj_ack_out, obj_err_out, obj_data_out}, {1'b1, e, d});
    @(negedge clk_sys_in);
  endtask : obj

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_enable;
    chk("reset_words", {resp_trailing_echo_out, resp_data_high_out, resp_data_low_out,
        resp_status_echo_out, 15'h0, service_enabled_out}, 80'h0);
    run(CMD_READ, 8'h05, 7'h01, 16'h2000, 32'h0);
    rsp(STS_NOT_ENABLED, 32'h0);
    chk("disabled_no_xfer", cap_n, 32'h0);
    run(CMD_ENABLE, NODE_SELF, 7'h01, 16'h0000, 32'h0);
    rsp({1'b0, STS_GENERAL[6:0]}, 32'h0);
    service_configured_in = 1'b1;
    run(CMD_ENABLE, NODE_SELF, 7'h01, 16'h0000, 32'h0);
    rsp(STS_OK, 32'h0);
    chk("enabled", service_enabled_out, 1'b1);
  endtask : s_enable

  task automatic s_errors;
    int i;
    for (i = 0; i < 14; i++)
    begin
      run(ERR_TAB[i][46:40], ERR_TAB[i][39:32], ERR_TAB[i][30:24], ERR_TAB[i][23:8], 32'h0);
      rsp(ERR_TAB[i][7:0], 32'h0);
    end
    chk("errors_no_xfer", cap_n, 32'h0);
  endtask : s_errors

  task automatic s_xfer;
    int i;
    for (i = 0; i < 6; i++)
    begin
      isl_res = 3'(i);
      isl_data = 32'h4433_2211 + 32'(i);
      isl_wait = i;
      run(CMD_READ, 8'h02, 7'h04, IDX_READ_MIN, 32'h0);
      rsp(RD_STS[i], (i < 2) ? isl_data : 32'h0);
      chk("read_req", cap[72:39], {2'h0, 8'h02, 16'h1000, 8'h03});
    end
    isl_res = XR_OK;
    run(CMD_WRITE, 8'h06, 7'h02, IDX_WRITE_MIN, 32'h0000_BEEF);
    rsp(STS_OK, isl_data);
    chk("write_req", cap[72:39], {2'h1, 8'h06, 16'h2000, 8'h03});
    chk("write_data", cap[38:0], {7'h02, 32'h0000_BEEF});
    run(CMD_CLR_HOTSWAP, 8'h20, 7'h01, 16'h0000, 32'h0);
    rsp(STS_OK, isl_data);
    chk("hotswap_req", cap[72:63], {2'h2, 8'h20});
  endtask : s_xfer

  task automatic s_overlap;
    int k;
    logic [7:0] rb;
    logic [31:0] n0;
    n0 = cap_n;
    isl_hold = 1'b1;
    isl_wait = 0;
    m_req = {CMD_READ, 8'h05, 7'h02, 16'h2000, 32'h0};
    start = 1'b1;
    @(negedge clk_sys_in);
    start = 1'b0;
    for (k = 0; k < 20 && xfer_req_out !== 1'b1; k++)
      @(negedge clk_sys_in);
    if (xfer_req_out !== 1'b1)
    begin
      fail_count++;
      print_verdict;
    end
    rb = req_cmd_node_in[15:8];
    m_req = {CMD_DISABLE, NODE_SELF, 7'h01, 16'h0000, 32'h0};
    start = 1'b1;
    @(negedge clk_sys_in);
    start = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    isl_hold = 1'b0;
    for (k = 0; k < 20 && resp_trailing_echo_out[7:0] !== rb; k++)
      @(negedge clk_sys_in);
    if (resp_trailing_echo_out[7:0] !== rb)
    begin
      fail_count++;
      print_verdict;
    end
    repeat (8) @(negedge clk_sys_in);
    chk("overlap_resp", resp_status_echo_out, {STS_OK, rb});
    chk("overlap_state", {service_enabled_out, cap_n}, {1'b1, n0 + 32'h1});
  endtask : s_overlap

  task automatic s_object;
    int i;
    logic [63:0] rw;
    rw = {resp_trailing_echo_out, resp_data_high_out, resp_data_low_out, resp_status_echo_out};
    for (i = 1; i < 5; i++)
      obj(RESP_OBJ_INDEX, 8'(i), 1'b0, rw[16 * (i - 1) +: 16]);
    obj(RESP_OBJ_INDEX, 8'h00, 1'b1, 16'h0000);
    obj(RESP_OBJ_INDEX, 8'h05, 1'b1, 16'h0000);
    obj(16'h4101, 8'h01, 1'b1, 16'h0000);
    @(negedge clk_sys_in);
    chk("obj_ack_once", obj_ack_out, 1'b0);
  endtask : s_object

  task automatic s_disable;
    run(CMD_DISABLE, NODE_SELF, 7'h01, 16'h0000, 32'h0);
    rsp(STS_DISABLED_OK, 32'h0);
    chk("disabled", service_enabled_out, 1'b0);
    run(CMD_WRITE, 8'h06, 7'h02, 16'h2000, 32'h0000_1234);
    rsp(STS_NOT_ENABLED, 32'h0);
  endtask : s_disable

  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    @(negedge clk_sys_in);
    s_enable;
    s_errors;
    s_xfer;
    s_overlap;
    s_object;
    s_disable;
    print_verdict;
  end
endmodule : tb_runtime_param_request_engine
